// >>> common/cbs_pkg.sv
// Shared constants and types for the bus cycle sequencer
`default_nettype none
package cbs_pkg;
  // ----------------------------------------
  // Bus constants
  // ----------------------------------------
  localparam logic [15:0] ADDR_DUMMY = 16'hFFFF; // Dummy cycles read the restart vector low byte
  localparam logic [15:0] PC_RESET = 16'h0000; // First opcode address after reset
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] PAGE_ZERO = 8'h00; // High byte of a direct address
  // ----------------------------------------
  // Cycle numbers
  // ----------------------------------------
  localparam logic [2:0] CYC_OPCODE = 3'h1; // Opcode fetch
  localparam logic [2:0] CYC_INLINE = 3'h2; // First inline byte
  localparam logic [2:0] CYC_IMM_LO = 3'h3; // Second immediate byte
  localparam logic [2:0] CYC_DIR_BASE = 3'h3; // First operand access, direct
  localparam logic [2:0] CYC_IDX_BASE = 3'h4; // First operand access, indexed
  localparam logic [2:0] LEN_IMM_ALU = 3'h2;
  localparam logic [2:0] LEN_IMM_LD16 = 3'h3;
  localparam logic [2:0] LEN_IMM_D16 = 3'h4;
  localparam logic [2:0] TAIL_ONE = 3'h1;
  localparam logic [2:0] TAIL_TWO = 3'h2;
  localparam logic [2:0] TAIL_THREE = 3'h3;
  localparam logic [2:0] TAIL_NONE = 3'h0;
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_SECOND = 3'h1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {M_IMM = 2'b00, M_DIR = 2'b01, M_IDX = 2'b10} cbs_mode_t;
  typedef enum logic [3:0] {
    K_ALU8 = 4'b0000, K_STA = 4'b0001, K_LD16 = 4'b0010, K_ST16 = 4'b0011, K_D16 = 4'b0100,
    K_RMW = 4'b0101, K_TST = 4'b0110, K_JMP = 4'b0111, K_JSR = 4'b1000
  } cbs_kind_t;
  typedef enum logic [2:0] {
    A_PC = 3'b000, A_FFFF = 3'b001, A_EA = 3'b010, A_EA1 = 3'b011, A_SP = 3'b100, A_SP1 = 3'b101, A_SPM = 3'b110
  } cbs_asel_t;
  typedef enum logic [2:0] {
    D_ACC = 3'b000, D_HI = 3'b001, D_LO = 3'b010, D_RETLO = 3'b011, D_RETHI = 3'b100, D_NEW = 3'b101
  } cbs_dsel_t;
  typedef enum logic [2:0] {
    T_NONE = 3'b000, T_CODE = 3'b001, T_OP8 = 3'b010, T_HI = 3'b011, T_LO = 3'b100, T_OFF = 3'b101,
    T_ADR = 3'b110, T_SUB = 3'b111
  } cbs_tag_t;
  typedef struct packed {
    cbs_asel_t asel;
    logic rnw;
    cbs_dsel_t dsel;
    cbs_tag_t tag;
  } cbs_step_t;
endpackage : cbs_pkg
`default_nettype wire

// >>> rtl/cbs_sequencer.sv
// Bus cycle sequencer for immediate, direct and indexed instructions
`default_nettype none
module cbs_sequencer import cbs_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data bus pins
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Address and direction pins
  output logic [15:0] addr,
  output logic rnw,
  // Opcode class, valid with the opcode on data_in in cycle 1
  input wire logic [1:0] cls_mode,
  input wire logic [3:0] cls_kind,
  // Register values from the core
  input wire logic [7:0] acc_val,
  input wire logic [15:0] reg16_val,
  input wire logic [7:0] new_val,
  input wire logic [15:0] idx_val,
  input wire logic [15:0] sp_val,
  // Captured read data towards the core
  output logic rd_valid,
  output logic [2:0] rd_tag,
  output logic [7:0] rd_data,
  output logic inst_done
);
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Cycles after the inline bytes, shared by direct and indexed
  function automatic logic [2:0] tail_len(cbs_kind_t k);
    unique case (k)
      K_ALU8, K_STA: tail_len = TAIL_ONE;
      K_LD16, K_ST16: tail_len = TAIL_TWO;
      K_D16, K_RMW, K_TST, K_JSR: tail_len = TAIL_THREE;
      default: tail_len = TAIL_NONE; // Jump and unused codes
    endcase
  endfunction : tail_len

  // Total cycles of an instruction
  function automatic logic [2:0] ncyc(cbs_mode_t m, cbs_kind_t k);
    if (m == M_IMM) begin
      unique case (k)
        K_LD16: ncyc = LEN_IMM_LD16;
        K_D16: ncyc = LEN_IMM_D16;
        default: ncyc = LEN_IMM_ALU;
      endcase
    end else if (m == M_DIR) begin
      ncyc = 3'(CYC_INLINE + tail_len(k));
    end else begin
      ncyc = 3'(CYC_DIR_BASE + tail_len(k));
    end
  endfunction : ncyc

  // What the bus does in cycle n (n >= 2)
  function automatic cbs_step_t step(cbs_mode_t m, cbs_kind_t k, logic [2:0] n);
    cbs_step_t s;
    logic [2:0] j;
    s = '{asel: A_PC, rnw: 1'b1, dsel: D_ACC, tag: T_NONE};
    j = (m == M_DIR) ? 3'(n - CYC_DIR_BASE) : 3'(n - CYC_IDX_BASE);
    if (m == M_IMM) begin
      // Inline operand bytes, then the dummy cycle
      if (n == CYC_INLINE) s.tag = (k == K_ALU8) ? T_OP8 : T_HI;
      else if (n == CYC_IMM_LO) s.tag = T_LO;
      else s.asel = A_FFFF;
    end else if (n == CYC_INLINE) begin
      // Direct address byte or index offset; a direct call's byte is treated as address only
      s.tag = (m == M_IDX) ? T_OFF : ((k == K_JSR) ? T_NONE : T_ADR);
    end else if (m == M_IDX && n == CYC_DIR_BASE) begin
      s.asel = A_FFFF;
    end else begin
      s.asel = A_EA;
      unique case (k)
        K_ALU8: s.tag = T_OP8;
        K_STA: s.rnw = 1'b0;
        K_LD16, K_D16: begin
          // High byte at the address, low at the next, arithmetic adds a dummy
          if (j == STEP_FIRST) s.tag = T_HI;
          else if (j == STEP_SECOND) begin
            s.asel = A_EA1;
            s.tag = T_LO;
          end else s.asel = A_FFFF;
        end
        K_ST16: begin
          s.rnw = 1'b0;
          s.dsel = (j == STEP_FIRST) ? D_HI : D_LO;
          if (j != STEP_FIRST) s.asel = A_EA1;
        end
        K_RMW, K_TST: begin
          if (j == STEP_FIRST) s.tag = T_OP8;
          else if (j == STEP_SECOND || k == K_TST) s.asel = A_FFFF;
          else begin
            s.rnw = 1'b0;
            s.dsel = D_NEW;
          end
        end
        K_JSR: begin
          if (j == STEP_FIRST) s.tag = T_SUB;
          else begin
            s.rnw = 1'b0;
            s.dsel = (j == STEP_SECOND) ? D_RETLO : D_RETHI;
            if (j == STEP_SECOND) s.asel = A_SP;
            else s.asel = (m == M_DIR) ? A_SP1 : A_SPM;
          end
        end
        default: s.asel = A_PC;
      endcase
    end
    step = s;
  endfunction : step

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [2:0] cyc_q; // Cycle number of the current bus cycle
  cbs_mode_t mode_q; // Mode of the instruction in flight
  cbs_kind_t kind_q; // Kind of the instruction in flight
  cbs_tag_t tag_q; // Meaning of the current read
  logic dummy_q; // Current cycle is a dummy read
  logic [15:0] pc_q; // Address of the next inline byte
  logic [15:0] ea_q; // Effective address
  logic [15:0] addr_q;
  logic rnw_q;
  logic [7:0] dout_q;
  logic oe_n_q;
  logic rd_valid_q;
  logic [2:0] rd_tag_q;
  logic [7:0] rd_data_q;
  logic done_q;

  // ----------------------------------------
  // Next bus cycle
  // ----------------------------------------
  cbs_mode_t mode_c; // Class taken straight from the decoder in cycle 1
  cbs_kind_t kind_c;
  logic last_c; // Current cycle ends the instruction
  cbs_step_t nxt_c; // Next cycle of the same instruction
  logic [15:0] ea_c; // Effective address including this cycle's byte
  logic [15:0] tgt_c; // Next opcode address
  logic [15:0] addr_d;

  always_comb begin
    mode_c = (cyc_q == CYC_OPCODE) ? cbs_mode_t'(cls_mode) : mode_q;
    kind_c = (cyc_q == CYC_OPCODE) ? cbs_kind_t'(cls_kind) : kind_q;
    last_c = (cyc_q == ncyc(mode_c, kind_c));
    nxt_c = step(mode_c, kind_c, 3'(cyc_q + CYC_OPCODE));
    ea_c = ea_q;
    if (cyc_q == CYC_INLINE) begin
      ea_c = (mode_c == M_IDX) ? 16'(idx_val + {PAGE_ZERO, data_in}) : {PAGE_ZERO, data_in};
    end
    // Jumps continue at the effective address; the subroutine opcode is fetched again there
    tgt_c = ((kind_c == K_JMP || kind_c == K_JSR) && mode_c != M_IMM) ? ea_c : pc_q;
    unique case (nxt_c.asel)
      A_FFFF: addr_d = ADDR_DUMMY;
      A_EA: addr_d = ea_c;
      A_EA1: addr_d = 16'(ea_c + ONE16);
      A_SP: addr_d = sp_val;
      A_SP1: addr_d = 16'(sp_val + ONE16);
      A_SPM: addr_d = 16'(sp_val - ONE16);
      default: addr_d = pc_q;
    endcase
    if (last_c) addr_d = tgt_c;
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  // Cycle counter and latched class
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_q <= CYC_OPCODE;
      mode_q <= M_IMM;
      kind_q <= K_ALU8;
      tag_q <= T_CODE;
      dummy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cyc_q <= last_c ? CYC_OPCODE : 3'(cyc_q + CYC_OPCODE);
      mode_q <= mode_c;
      kind_q <= kind_c;
      tag_q <= last_c ? T_CODE : nxt_c.tag;
      dummy_q <= !last_c && (nxt_c.asel == A_FFFF);
      done_q <= last_c;
    end
  end

  // Program counter and effective address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= 16'(PC_RESET + ONE16);
      ea_q <= PC_RESET;
    end else begin
      ea_q <= ea_c;
      if (last_c) pc_q <= 16'(tgt_c + ONE16); // Past the opcode about to be fetched
      else if (nxt_c.asel == A_PC) pc_q <= 16'(pc_q + ONE16);
    end
  end

  // ----------------------------------------
  // Bus pins
  // ----------------------------------------
  // Address, direction and write data all come from flops for a clean cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= PC_RESET;
      rnw_q <= 1'b1;
      oe_n_q <= 1'b1;
      dout_q <= '0;
    end else begin
      addr_q <= addr_d;
      rnw_q <= last_c ? 1'b1 : nxt_c.rnw;
      oe_n_q <= last_c ? 1'b1 : nxt_c.rnw; // Drive only in write cycles
      unique case (nxt_c.dsel)
        D_HI: dout_q <= reg16_val[15:8];
        D_LO: dout_q <= reg16_val[7:0];
        D_RETLO: dout_q <= pc_q[7:0];
        D_RETHI: dout_q <= pc_q[15:8];
        D_NEW: dout_q <= new_val;
        default: dout_q <= acc_val;
      endcase
    end
  end

  // ----------------------------------------
  // Read capture
  // ----------------------------------------
  // Dummy reads and don't-care bytes are dropped here so the core never sees them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_tag_q <= T_NONE;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= rnw_q && !dummy_q && (tag_q != T_NONE);
      rd_tag_q <= tag_q;
      rd_data_q <= data_in;
    end
  end

  assign addr = addr_q;
  assign rnw = rnw_q;
  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;
  assign rd_valid = rd_valid_q;
  assign rd_tag = rd_tag_q;
  assign rd_data = rd_data_q;
  assign inst_done = done_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Antecedents also need rst_n as sampled: the release edge would otherwise start a check on pre-reset state
  AST_DRIVE_DIR: assert property (@(posedge clk) disable iff (!rst_n) (data_oe_n == rnw))
    else $error("data drive does not follow read/write level");
  AST_INLINE_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (cyc_q == CYC_OPCODE && !last_c) |=> (addr == $past(addr) + ONE16) && rnw)
    else $error("first inline byte not at opcode address plus one");
  AST_IMM_ALU: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (cyc_q == CYC_OPCODE && cls_mode == M_IMM && cls_kind == K_ALU8)
    |=> (cyc_q == CYC_INLINE) ##1 (cyc_q == CYC_OPCODE) && rd_valid && (rd_tag == T_OP8))
    else $error("immediate operation not two cycles with operand captured");
  AST_DUMMY_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && dummy_q |-> (addr == ADDR_DUMMY) && rnw ##1 !rd_valid)
    else $error("dummy read not at all-ones or passed to core");
  AST_IDX_DUMMY: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (cyc_q == CYC_INLINE && mode_q == M_IDX) |=> (addr == ADDR_DUMMY) && rnw)
    else $error("indexed third cycle not a dummy read");
  AST_D16_END: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (inst_done && $past(kind_q) == K_D16) |-> $past(dummy_q))
    else $error("16-bit arithmetic does not end on a dummy read");
  AST_DIR_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (mode_q == M_DIR && kind_q == K_JSR && cyc_q == CYC_DIR_BASE) |=> !rnw ##1 !rnw && addr == $past(addr) + ONE16)
    else $error("direct call stack writes wrong");
  AST_IDX_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (mode_q == M_IDX && kind_q == K_JSR && cyc_q == CYC_IDX_BASE) |=> !rnw ##1 !rnw && addr == $past(addr) - ONE16)
    else $error("indexed call stack writes wrong");
  AST_RMW_BACK: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (mode_q == M_IDX && kind_q == K_RMW && cyc_q == CYC_IDX_BASE) |=> dummy_q ##1 !rnw && addr == ea_q)
    else $error("read-modify-write does not write back");
  AST_TST_READ: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (mode_q == M_IDX && kind_q == K_TST && cyc_q == CYC_IDX_BASE) |=> ##1 rnw && addr == ADDR_DUMMY)
    else $error("test operand sixth cycle not a dummy read");
  AST_ST16_PAIR: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && (kind_q == K_ST16 && !rnw && cyc_q == CYC_IDX_BASE && mode_q == M_IDX) |=> !rnw && addr == $past(addr) + ONE16)
    else $error("indexed 16-bit store not at consecutive addresses");
endmodule : cbs_sequencer
`default_nettype wire

// >>> tb/cbs_mem_model.sv
// Memory model standing on the far side of the processor bus
`default_nettype none
module cbs_mem_model (
  // Clock
  input wire logic clk,
  // Bus from the core
  input wire logic [15:0] addr,
  input wire logic rnw,
  input wire logic data_oe_n,
  input wire logic [7:0] data_out,
  // Read data back to the core
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535]; // Whole space, no wait states
  logic [7:0] last_q = 8'h00; // Last byte handed out
  // ----------------------------------------
  // Contents
  // ----------------------------------------
  // Distinct pattern, so a wrong address shows as wrong data
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i ^ (i >> 8) ^ 8'h3C);
    end
  end
  // Combinational answer; while the core drives, show the inverse
  // of the last byte so stale data can never pass for a match
  assign data_in = rnw ? mem[addr] : ~last_q;
  // Writes land at the edge that ends the write cycle
  always @(posedge clk) begin
    if (rnw) begin
      last_q <= mem[addr];
    end else if (!data_oe_n) begin
      mem[addr] = data_out;
    end
  end
endmodule : cbs_mem_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the bus cycle sequencer
`default_nettype none
module testbench import cbs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n;
  logic [7:0] data_in, data_out, acc_val, new_val, rd_data;
  logic data_oe_n, rnw, rd_valid, inst_done;
  logic [15:0] addr, reg16_val, idx_val, sp_val;
  logic [1:0] cls_mode;
  logic [3:0] cls_kind;
  logic [2:0] rd_tag;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0; // Hang guard
  // Expected bus cycles: address, direction, capture tag, write data
  logic [15:0] e_addr [$];
  logic e_rnw [$];
  logic [2:0] e_tag [$];
  logic [7:0] e_dout [$];
  cbs_sequencer dut (.clk(clk), .rst_n(rst_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .addr(addr), .rnw(rnw), .cls_mode(cls_mode), .cls_kind(cls_kind),
    .acc_val(acc_val), .reg16_val(reg16_val), .new_val(new_val), .idx_val(idx_val),
    .sp_val(sp_val), .rd_valid(rd_valid), .rd_tag(rd_tag), .rd_data(rd_data), .inst_done(inst_done));
  cbs_mem_model mem_i (.clk(clk), .addr(addr), .rnw(rnw), .data_oe_n(data_oe_n),
    .data_out(data_out), .data_in(data_in));
  initial forever #2.5 clk = ~clk;
  // Whole run needs about 130 cycles; far above that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  // Queue one expected bus cycle
  task automatic cy(input logic [15:0] a, input logic r, input logic [2:0] t, input logic [7:0] d = 8'h00);
    e_addr.push_back(a);
    e_rnw.push_back(r);
    e_tag.push_back(t);
    e_dout.push_back(d);
  endtask : cy
  // Opcode at 0000, inline byte at 0001; indexed adds the dummy read
  task automatic head(input logic [7:0] b1, input logic [2:0] t, input logic idx);
    mem_i.mem[0] = 8'h8C;
    mem_i.mem[1] = b1;
    cy(16'h0000, 1'b1, 3'h1);
    cy(16'h0001, 1'b1, t);
    if (idx) cy(16'hFFFF, 1'b1, 3'h0);
  endtask : head
  // Reset mid-run so every instruction starts at 0000, then walk it
  // The opcode fetch stands in the cycle right after the release edge; nxt is the following opcode address
  task automatic run_seq(input logic [1:0] m, input logic [3:0] k, input logic [15:0] nxt);
    int n;
    n = e_addr.size();
    @(posedge clk);
    rst_n <= 1'b0;
    cls_mode <= m;
    cls_kind <= k;
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (i < n) begin
        check_val("addr", e_addr[i], addr);
        check_val("rnw", 16'(e_rnw[i]), 16'(rnw));
        check_val("data_oe_n", 16'(e_rnw[i]), 16'(data_oe_n));
        if (!e_rnw[i]) check_val("data_out", 16'(e_dout[i]), 16'(data_out));
      end else begin
        check_val("next opcode addr", nxt, addr);
      end
      if (i > 0) begin
        check_val("rd_valid", 16'(e_tag[i-1] != 3'h0), 16'(rd_valid));
        if (e_tag[i-1] != 3'h0) begin
          check_val("rd_tag", 16'(e_tag[i-1]), 16'(rd_tag));
          check_val("rd_data", 16'(mem_i.mem[e_addr[i-1]]), 16'(rd_data));
        end
      end
      check_val("inst_done", 16'(i == n), 16'(inst_done));
      @(posedge clk);
    end
    e_addr.delete();
    e_rnw.delete();
    e_tag.delete();
    e_dout.delete();
  endtask : run_seq
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_imm_alu();
    head(8'h42, 3'h2, 1'b0);
    run_seq(M_IMM, K_ALU8, 16'h0002);
  endtask : sc_imm_alu
  task automatic sc_imm_ld16();
    head(8'h12, 3'h3, 1'b0);
    cy(16'h0002, 1'b1, 3'h4);
    run_seq(M_IMM, K_LD16, 16'h0003);
  endtask : sc_imm_ld16
  task automatic sc_imm_d16();
    head(8'h12, 3'h3, 1'b0);
    cy(16'h0002, 1'b1, 3'h4);
    cy(16'hFFFF, 1'b1, 3'h0);
    run_seq(M_IMM, K_D16, 16'h0003);
  endtask : sc_imm_d16
  task automatic sc_dir_alu();
    head(8'h55, 3'h6, 1'b0);
    cy(16'h0055, 1'b1, 3'h2);
    run_seq(M_DIR, K_ALU8, 16'h0002);
  endtask : sc_dir_alu
  // Operand at the top of page zero: the low byte crosses into 0100
  task automatic sc_dir_ld16();
    head(8'hFF, 3'h6, 1'b0);
    cy(16'h00FF, 1'b1, 3'h3);
    cy(16'h0100, 1'b1, 3'h4);
    run_seq(M_DIR, K_LD16, 16'h0002);
  endtask : sc_dir_ld16
  task automatic sc_dir_sta();
    head(8'h70, 3'h6, 1'b0);
    cy(16'h0070, 1'b0, 3'h0, 8'h5A);
    run_seq(M_DIR, K_STA, 16'h0002);
  endtask : sc_dir_sta
  task automatic sc_dir_st16();
    head(8'h80, 3'h6, 1'b0);
    cy(16'h0080, 1'b0, 3'h0, 8'hC3);
    cy(16'h0081, 1'b0, 3'h0, 8'hA5);
    run_seq(M_DIR, K_ST16, 16'h0002);
  endtask : sc_dir_st16
  task automatic sc_dir_d16();
    head(8'h90, 3'h6, 1'b0);
    cy(16'h0090, 1'b1, 3'h3);
    cy(16'h0091, 1'b1, 3'h4);
    cy(16'hFFFF, 1'b1, 3'h0);
    run_seq(M_DIR, K_D16, 16'h0002);
  endtask : sc_dir_d16
  // Return address 0002 goes low byte first, stack ascending
  task automatic sc_dir_jsr();
    head(8'h40, 3'h0, 1'b0);
    cy(16'h0040, 1'b1, 3'h7);
    cy(16'h01F0, 1'b0, 3'h0, 8'h02);
    cy(16'h01F1, 1'b0, 3'h0, 8'h00);
    run_seq(M_DIR, K_JSR, 16'h0040);
  endtask : sc_dir_jsr
  task automatic sc_idx_jmp();
    head(8'h20, 3'h5, 1'b1);
    run_seq(M_IDX, K_JMP, 16'h0010);
  endtask : sc_idx_jmp
  // Index FFF0 plus offset 20 wraps to 0010
  task automatic sc_idx_sta();
    head(8'h20, 3'h5, 1'b1);
    cy(16'h0010, 1'b0, 3'h0, 8'h5A);
    run_seq(M_IDX, K_STA, 16'h0002);
  endtask : sc_idx_sta
  task automatic sc_idx_ld16();
    head(8'h20, 3'h5, 1'b1);
    cy(16'h0010, 1'b1, 3'h3);
    cy(16'h0011, 1'b1, 3'h4);
    run_seq(M_IDX, K_LD16, 16'h0002);
  endtask : sc_idx_ld16
  task automatic sc_idx_d16();
    head(8'h20, 3'h5, 1'b1);
    cy(16'h0010, 1'b1, 3'h3);
    cy(16'h0011, 1'b1, 3'h4);
    cy(16'hFFFF, 1'b1, 3'h0);
    run_seq(M_IDX, K_D16, 16'h0002);
  endtask : sc_idx_d16
  // Read-modify-write and its test variant share cycles 1 to 5
  task automatic sc_idx_rmw(input logic tst);
    head(8'h24, 3'h5, 1'b1);
    cy(16'h0014, 1'b1, 3'h2);
    cy(16'hFFFF, 1'b1, 3'h0);
    if (tst) cy(16'hFFFF, 1'b1, 3'h0);
    else cy(16'h0014, 1'b0, 3'h0, 8'h96);
    run_seq(M_IDX, tst ? K_TST : K_RMW, 16'h0002);
  endtask : sc_idx_rmw
  // Return address high byte goes one below the stack pointer
  task automatic sc_idx_jsr();
    head(8'h30, 3'h5, 1'b1);
    cy(16'h0020, 1'b1, 3'h7);
    cy(16'h01F0, 1'b0, 3'h0, 8'h02);
    cy(16'h01EF, 1'b0, 3'h0, 8'h00);
    run_seq(M_IDX, K_JSR, 16'h0020);
  endtask : sc_idx_jsr
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n <= 1'b0;
    cls_mode <= M_IMM;
    cls_kind <= K_ALU8;
    acc_val <= 8'h5A;
    reg16_val <= 16'hC3A5;
    new_val <= 8'h96;
    idx_val <= 16'hFFF0;
    sp_val <= 16'h01F0;
    repeat (12) @(posedge clk);
    sc_imm_alu();
    sc_imm_ld16();
    sc_imm_d16();
    sc_dir_alu();
    sc_dir_ld16();
    sc_dir_sta();
    sc_dir_st16();
    sc_dir_d16();
    sc_dir_jsr();
    sc_idx_jmp();
    sc_idx_sta();
    sc_idx_ld16();
    sc_idx_d16();
    sc_idx_rmw(1'b0);
    sc_idx_rmw(1'b1);
    sc_idx_jsr();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
